// ==== als_led_model.sv ====
`default_nettype none
module als_led_model (
	// pin from the block
	input wire logic pin_o,
	input wire logic pin_oe,
	// board wiring: level that lights the lamp
	input wire logic on_level,
	// lamp state
	output logic lit
);
	timeunit 1ns;
	timeprecision 1ps;
	// a pin not driven leaves the lamp dark, whatever it last showed
	assign lit = pin_oe & (pin_o === on_level);
endmodule
`default_nettype wire

// ==== als_pkg.sv ====
`default_nettype none
package als_pkg;
	localparam int CLK_MHZ = 100;
	localparam int HOLD_LONG_MS = 64;
	localparam int HOLD_SHORT_MS = 1;
	localparam int HOLD_TEST_NS = 3800;
	localparam int HOLD_LONG_CYC = HOLD_LONG_MS * 1000 * CLK_MHZ;
	localparam int HOLD_SHORT_CYC = HOLD_SHORT_MS * 1000 * CLK_MHZ;
	localparam int HOLD_TEST_CYC = (HOLD_TEST_NS * CLK_MHZ) / 1000;
	localparam int CNT_W = 23;
	localparam int NSRC = 5;

	typedef enum logic [1:0] {
		ALS_DUR_LONG = 2'b00,
		ALS_DUR_TEST = 2'b01,
		ALS_DUR_THRU = 2'b10,
		ALS_DUR_SHORT = 2'b11
	} als_dur_t;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LINK = 8'h04;
	localparam logic [7:0] OFS_CARD0 = 8'h08;
	localparam logic [7:0] OFS_CARD3 = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam int CTRL_PIN_BIT = 0;
	localparam int CTRL_POL_BIT = 30;
	localparam int LINK_DUR_LO = 1;
	localparam int LINK_EN_BIT = 3;
	localparam int CARD_DUR_LO = 28;
	localparam int CARD_EN_BIT = 6;
	localparam int STAT_BUSY_BIT = 8;
	localparam logic RST_POL = 1'b0;
	localparam logic RST_PIN = 1'b0;
	localparam logic RST_EN = 1'b0;
	localparam logic [1:0] RST_DUR = 2'b00;
endpackage
`default_nettype wire

// ==== als_stretch.sv ====
`default_nettype none
module als_stretch #(
	parameter int LONG_CYC = als_pkg::HOLD_LONG_CYC,
	parameter int SHORT_CYC = als_pkg::HOLD_SHORT_CYC,
	parameter int TEST_CYC = als_pkg::HOLD_TEST_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// source
	input wire logic trig,
	input wire logic [1:0] dur,
	// result
	output logic ind,
	output logic busy
);
	logic run_q;
	logic [als_pkg::CNT_W-1:0] cnt_q;
	logic [als_pkg::CNT_W-1:0] term;
	logic thru;

	assign thru = (dur == als_pkg::ALS_DUR_THRU);

	always_comb begin
		unique case (als_pkg::als_dur_t'(dur))
			als_pkg::ALS_DUR_LONG: term = als_pkg::CNT_W'(LONG_CYC);
			als_pkg::ALS_DUR_TEST: term = als_pkg::CNT_W'(TEST_CYC);
			als_pkg::ALS_DUR_THRU: term = als_pkg::CNT_W'(1);
			als_pkg::ALS_DUR_SHORT: term = als_pkg::CNT_W'(SHORT_CYC);
		endcase
	end

	// armed while the trigger is high, so the hold starts on its fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0; // R18
			cnt_q <= '0;
		end else if (trig) begin
			run_q <= !thru; // R6 R19
			cnt_q <= '0; // R7
		end else if (run_q) begin
			if (thru || cnt_q == term - als_pkg::CNT_W'(1)) begin
				run_q <= 1'b0; // R6
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + als_pkg::CNT_W'(1);
			end
		end
	end

	assign ind = trig | (run_q & !thru); // R5 R6 R19
	assign busy = run_q & !thru; // R9 R19

	property p_no_delay;
		@(posedge pclk) disable iff (!presetn) trig |-> ind;
	endproperty
	a_no_delay: assert property (p_no_delay) else $error("indication lags trigger"); // R5

	property p_thru_follows;
		@(posedge pclk) disable iff (!presetn) thru |-> (ind == trig) && !busy;
	endproperty
	a_thru_follows: assert property (p_thru_follows) else $error("pass-through not direct"); // R19

	// check helper: cycles since the trigger fell, only after a trigger seen in test mode
	logic seen_q;
	logic [als_pkg::CNT_W-1:0] low_cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 1'b0;
			low_cnt_q <= '0;
		end else if (dur != als_pkg::ALS_DUR_TEST) begin
			seen_q <= 1'b0;
			low_cnt_q <= '0;
		end else if (trig) begin
			seen_q <= 1'b1;
			low_cnt_q <= '0;
		end else if (low_cnt_q != '1) begin
			low_cnt_q <= low_cnt_q + als_pkg::CNT_W'(1);
		end
	end

	property p_test_hold;
		@(posedge pclk) disable iff (!presetn)
		(dur == als_pkg::ALS_DUR_TEST && seen_q && !trig && low_cnt_q < als_pkg::CNT_W'(TEST_CYC)) |-> ind;
	endproperty
	a_test_hold: assert property (p_test_hold) else $error("test hold ended early"); // R6

	property p_test_end;
		@(posedge pclk) disable iff (!presetn)
		(dur == als_pkg::ALS_DUR_TEST && $fell(trig)) |-> ##[0:400] (!ind || trig || dur != als_pkg::ALS_DUR_TEST);
	endproperty
	a_test_end: assert property (p_test_end) else $error("test hold never ended"); // R6

	property p_restart;
		@(posedge pclk) disable iff (!presetn) trig |=> cnt_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("counter not cleared by trigger"); // R7
endmodule
`default_nettype wire

// ==== als_top.sv ====
// Functional notes
// R1: indicator is the OR of all enabled per-source indications.
// R2: indicator appears on user pin zero when the pin select bit is set.
// R3: indicator active low after reset; polarity bit one makes it active high.
// R4: one polarity bit serves all five sources.
// R5: indication asserts in the same cycle as its trigger.
// R6: after trigger falls, hold for the selected time, default 64 ms, then drop.
// R7: trigger return during hold clears counter; timing restarts on next fall.
// R8: every source has its own hold selection and trigger.
// R9: hold counters run on the bus clock; busy counters refuse clock-stop requests.
// R10: software wanting clock stop shortens hold or picks pass-through.
// R11: link hold code at bits 2:1: 00 64ms, 11 1ms, 10 through, 01 test.
// R12: cards zero and one hold code at bits 29:28, same encoding.
// R13: cards two and three hold code at bits 29:28, same encoding.
// R14: link trigger is transmit or receive.
// R15: cards zero and one trigger on transmit, receive or card-detect debounce.
// R16: cards two and three trigger on transmit or receive only.
// R17: source enable: link bit 3, each card bit 6.
// R18: hold intervals from fixed terminal counts; reset clears counters and indications.
// R19: pass-through follows trigger and never holds off clock-stop.
`default_nettype none
module als_top #(
	parameter int LONG_CYC = als_pkg::HOLD_LONG_CYC,
	parameter int SHORT_CYC = als_pkg::HOLD_SHORT_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// activity triggers
	input wire logic link_tx,
	input wire logic link_rx,
	input wire logic [3:0] card_tx,
	input wire logic [3:0] card_rx,
	input wire logic [1:0] card_debounce,
	// clock-stop handshake
	input wire logic clkrun_stop_req,
	output logic clkrun_stop_refuse,
	// indicator pin
	output logic user_io_pin_zero_o,
	output logic user_io_pin_zero_oe
);
	logic ctrl_pol_q;
	logic ctrl_pin_q;
	logic [als_pkg::NSRC-1:0] en_q;
	logic [1:0] dur_q [als_pkg::NSRC];
	logic [als_pkg::NSRC-1:0] trig;
	logic [als_pkg::NSRC-1:0] ind;
	logic [als_pkg::NSRC-1:0] busy;
	logic any_act;
	logic any_busy;
	logic activity_indicator_n;
	logic acc;
	logic wr_en;
	logic hit;
	logic [31:0] rd_d;
	logic [2:0] card_idx;

	assign trig[0] = link_tx | link_rx; // R14
	assign trig[1] = card_tx[0] | card_rx[0] | card_debounce[0]; // R15
	assign trig[2] = card_tx[1] | card_rx[1] | card_debounce[1]; // R15
	assign trig[3] = card_tx[2] | card_rx[2]; // R16
	assign trig[4] = card_tx[3] | card_rx[3]; // R16

	for (genvar g = 0; g < als_pkg::NSRC; g++) begin : g_src
		als_stretch #(
			.LONG_CYC(LONG_CYC),
			.SHORT_CYC(SHORT_CYC),
			.TEST_CYC(als_pkg::HOLD_TEST_CYC)
		) u_str (
			.pclk(pclk),
			.presetn(presetn),
			.trig(trig[g]),
			.dur(dur_q[g]), // R8
			.ind(ind[g]),
			.busy(busy[g])
		);
	end

	assign any_act = |(ind & en_q); // R1 R17
	assign any_busy = |busy;
	// polarity selects level of the shared output
	assign activity_indicator_n = ctrl_pol_q ? any_act : !any_act; // R3 R4

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_io_pin_zero_o <= 1'b1; // R3
			user_io_pin_zero_oe <= als_pkg::RST_PIN;
		end else begin
			user_io_pin_zero_o <= activity_indicator_n; // R1
			user_io_pin_zero_oe <= ctrl_pin_q; // R2
		end
	end

	// refuse only when a stop is actually asked for while a hold runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkrun_stop_refuse <= 1'b0;
		end else begin
			clkrun_stop_refuse <= clkrun_stop_req & any_busy; // R9
		end
	end

	// one wait state: pready rises in the second access cycle
	assign acc = psel & penable;
	assign wr_en = acc & pready & pwrite;
	assign card_idx = 3'((paddr - als_pkg::OFS_CARD0) >> 2);
	assign hit = (paddr == als_pkg::OFS_CTRL) || (paddr == als_pkg::OFS_LINK) || (paddr == als_pkg::OFS_STATUS)
		|| (paddr >= als_pkg::OFS_CARD0 && paddr <= als_pkg::OFS_CARD3 && paddr[1:0] == 2'b00);

	always_comb begin
		rd_d = 32'h0000_0000;
		if (paddr == als_pkg::OFS_CTRL) begin
			rd_d[als_pkg::CTRL_POL_BIT] = ctrl_pol_q;
			rd_d[als_pkg::CTRL_PIN_BIT] = ctrl_pin_q;
		end else if (paddr == als_pkg::OFS_LINK) begin
			rd_d[als_pkg::LINK_DUR_LO +: 2] = dur_q[0];
			rd_d[als_pkg::LINK_EN_BIT] = en_q[0];
		end else if (paddr == als_pkg::OFS_STATUS) begin
			rd_d[als_pkg::NSRC-1:0] = ind;
			rd_d[als_pkg::STAT_BUSY_BIT] = any_busy;
		end else if (hit) begin
			rd_d[als_pkg::CARD_DUR_LO +: 2] = dur_q[card_idx + 3'h1];
			rd_d[als_pkg::CARD_EN_BIT] = en_q[card_idx + 3'h1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc & !pready;
			pslverr <= acc & !pready & !hit;
			if (acc && !pready && !pwrite) begin
				prdata <= rd_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_pol_q <= als_pkg::RST_POL; // R3
			ctrl_pin_q <= als_pkg::RST_PIN;
		end else if (wr_en && paddr == als_pkg::OFS_CTRL) begin
			ctrl_pol_q <= pwdata[als_pkg::CTRL_POL_BIT]; // R3 R4
			ctrl_pin_q <= pwdata[als_pkg::CTRL_PIN_BIT]; // R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= {als_pkg::NSRC{als_pkg::RST_EN}};
			for (int i = 0; i < als_pkg::NSRC; i++) begin
				dur_q[i] <= als_pkg::RST_DUR; // R6
			end
		end else if (wr_en && paddr == als_pkg::OFS_LINK) begin
			dur_q[0] <= pwdata[als_pkg::LINK_DUR_LO +: 2]; // R11
			en_q[0] <= pwdata[als_pkg::LINK_EN_BIT]; // R17
		end else if (wr_en && hit && paddr >= als_pkg::OFS_CARD0 && paddr <= als_pkg::OFS_CARD3) begin
			dur_q[card_idx + 3'h1] <= pwdata[als_pkg::CARD_DUR_LO +: 2]; // R12 R13
			en_q[card_idx + 3'h1] <= pwdata[als_pkg::CARD_EN_BIT]; // R17
		end
	end

	property p_out_level;
		@(posedge pclk) disable iff (!presetn)
		##1 user_io_pin_zero_o == ($past(ctrl_pol_q) ? $past(any_act) : !$past(any_act));
	endproperty
	a_out_level: assert property (p_out_level) else $error("indicator level wrong"); // R3

	property p_enabled_shows;
		@(posedge pclk) disable iff (!presetn) (trig[0] && en_q[0] && !ctrl_pol_q) |=> !user_io_pin_zero_o;
	endproperty
	a_enabled_shows: assert property (p_enabled_shows) else $error("link activity not shown"); // R1

	property p_disabled_quiet;
		@(posedge pclk) disable iff (!presetn) (en_q == '0 && !ctrl_pol_q) |=> user_io_pin_zero_o;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source shows"); // R17

	property p_refuse;
		@(posedge pclk) disable iff (!presetn) (clkrun_stop_req && any_busy) |=> clkrun_stop_refuse;
	endproperty
	a_refuse: assert property (p_refuse) else $error("clock stop not refused"); // R9

	property p_pin_sel;
		@(posedge pclk) disable iff (!presetn) ##1 user_io_pin_zero_oe == $past(ctrl_pin_q);
	endproperty
	a_pin_sel: assert property (p_pin_sel) else $error("pin enable wrong"); // R2
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG = 50;
	localparam int SHORT = 20;
	localparam int TEST = 380;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic link_tx, link_rx, clkrun_stop_req, clkrun_stop_refuse, pin_o, pin_oe, on_level, lit;
	logic [3:0] card_tx, card_rx;
	logic [1:0] card_debounce;
	int err_count, checks_done;
	// per card: setting, trigger, hold, refuse expected
	logic [31:0] cfg[4] = '{32'h2000_0040, 32'h0000_0040, 32'h3000_0040, 32'h1000_0040};
	int src[4] = '{10, 11, 8, 5};
	int hld[4] = '{0, LONG, SHORT, TEST};
	als_top #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_tx(link_tx), .link_rx(link_rx), .card_tx(card_tx),
		.card_rx(card_rx), .card_debounce(card_debounce), .clkrun_stop_req(clkrun_stop_req),
		.clkrun_stop_refuse(clkrun_stop_refuse), .user_io_pin_zero_o(pin_o), .user_io_pin_zero_oe(pin_oe));
	als_led_model led (.pin_o(pin_o), .pin_oe(pin_oe), .on_level(on_level), .lit(lit));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic xerr);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready, prdata and pslverr are taken at the rising edge that ends the access
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			summarize();
		end
		chk("pslverr", xerr, err);
		@(posedge pclk);
	endtask
	task automatic drive(input int s, input logic v);
		case (s)
			0: link_tx <= v;
			1: link_rx <= v;
			2, 3, 4, 5: card_tx[s-2] <= v;
			6, 7, 8, 9: card_rx[s-6] <= v;
			default: card_debounce[s-10] <= v;
		endcase
	endtask
	task automatic burst(input int s, input int hold, input logic on, input logic rf, input bit re);
		int n;
		drive(s, 1'b1);
		@(posedge pclk);
		@(negedge pclk);
		chk("lit", on, lit);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk("refuse", rf, clkrun_stop_refuse);
		@(posedge pclk);
		drive(s, 1'b0);
		if (re) begin
			repeat (hold / 2) @(posedge pclk);
			drive(s, 1'b1);
			@(posedge pclk);
			drive(s, 1'b0);
		end
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (lit === 1'b1 && n < 1000);
		if (on) chk("hold", 32'h1, 32'(n >= hold && n <= hold + 3));
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("refuse_end", 1'b0, clkrun_stop_refuse);
		@(posedge pclk);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		err_count++;
		summarize();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, link_tx, link_rx} = '0;
		{card_tx, card_rx, card_debounce, clkrun_stop_req, on_level} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("pin_idle", 1'b1, pin_o);
		chk("pin_oe", 1'b0, pin_oe);
		@(posedge pclk);
		apb(1'b0, als_pkg::OFS_CTRL, 32'h0, 1'b0);
		chk("ctrl", 32'h0, rd);
		apb(1'b1, als_pkg::OFS_CTRL, 32'h1, 1'b0);
		@(negedge pclk);
		chk("pin_oe", 1'b1, pin_oe);
		@(posedge pclk);
		burst(2, LONG, 1'b0, 1'b0, 1'b0);
		clkrun_stop_req <= 1'b1;
		apb(1'b1, als_pkg::OFS_LINK, 32'h8, 1'b0);
		burst(0, LONG, 1'b1, 1'b1, 1'b1);
		apb(1'b1, als_pkg::OFS_LINK, 32'hE, 1'b0);
		burst(1, SHORT, 1'b1, 1'b1, 1'b0);
		apb(1'b1, als_pkg::OFS_LINK, 32'hA, 1'b0);
		burst(0, TEST, 1'b1, 1'b1, 1'b0);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'(als_pkg::OFS_CARD0 + 4 * k), cfg[k], 1'b0);
			burst(src[k], hld[k], 1'b1, 1'(k != 0), 1'b0);
		end
		apb(1'b1, als_pkg::OFS_CTRL, 32'h4000_0001, 1'b0);
		on_level <= 1'b1;
		@(negedge pclk);
		chk("pin_idle_hi", 1'b0, pin_o);
		@(posedge pclk);
		burst(4, SHORT, 1'b1, 1'b1, 1'b0);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF, 1'b1);
		apb(1'b0, 8'h40, 32'h0, 1'b1);
		chk("unmapped", 32'h0, rd);
		drive(0, 1'b1);
		repeat (3) @(posedge pclk);
		apb(1'b0, als_pkg::OFS_STATUS, 32'h0, 1'b0);
		chk("status", 32'h0000_0101, rd);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("pin_rst", 1'b1, pin_o);
		chk("pin_oe_rst", 1'b0, pin_oe);
		chk("refuse_rst", 1'b0, clkrun_stop_refuse);
		@(posedge pclk);
		drive(0, 1'b0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, als_pkg::OFS_CTRL, 32'h0, 1'b0);
		chk("ctrl_rst", 32'h0, rd);
		summarize();
	end
endmodule
`default_nettype wire
